// ===== rtl/qp_spi_slave.sv
// Behaviour
// - mode 0 slave only, chip select framed
// - sample data on clock rise, select low
// - shift data out on clock fall
// - most significant bit first, both directions
// - instruction byte: opcode high, address low
// - addresses 0-3 wipers, 10h access control
// - 8-bit wiper register sets tap position
// - power-up loads every wiper with 40h
// - wipers writable and readable over serial
// - control bit 1 selects open-drain output
// - control bit 6 low means shutdown
// - shutdown keeps wiper values unchanged
// - supply dip in shutdown resets wipers
// - select high: standby, output released
// - first select fall needed after reset
// - writes execute on select rising edge
// - opcode set: nop, control, register access
// - read returns marker byte then data byte
// - read reply preceded by 111 and address
`timescale 1ns/10ps
`include "qp_defs.svh"

module qp_spi_slave import qp_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic supply_low,
  output logic sdo_o,
  output logic sdo_oe,
  output logic shutdown_n,
  output logic [7:0] wiper_pos_0,
  output logic [7:0] wiper_pos_1,
  output logic [7:0] wiper_pos_2,
  output logic [7:0] wiper_pos_3
);

  qp_core_s st_r;
  qp_core_s st_nxt;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic in_frame;
  logic [15:0] shifted;
  logic [16:0] rd_new;
  logic [16:0] rd_end;
  logic [7:0] acr_val;
  logic [3:0][7:0] wp;
  logic wr_en;
  logic [1:0] wr_idx;
  logic [7:0] wr_data;
  logic mid_rst;

  // edges come from the second and third sync stages only
  assign sck_rise = st_r.sck_s & ~st_r.sck_d;
  assign sck_fall = ~st_r.sck_s & st_r.sck_d;
  assign cs_fall = ~st_r.cs_s & st_r.cs_d;
  assign cs_rise = st_r.cs_s & ~st_r.cs_d;
  assign in_frame = st_r.state == QP_ST_FRAME;

  assign wp[0] = wiper_pos_0;
  assign wp[1] = wiper_pos_1;
  assign wp[2] = wiper_pos_2;
  assign wp[3] = wiper_pos_3;

  always_comb begin
    acr_val = 8'h00;
    acr_val[`QP_ACR_SHUTDOWN_N_BIT_BIT] = st_r.acr_shutdown_n_bit_n;
    acr_val[`QP_ACR_OD_BIT] = st_r.acr_od;
  end

  // returns {hit, 111b, address, data} for a read word
  function automatic logic [16:0] read_resp(input logic [15:0] w);
    logic [2:0] op;
    logic [4:0] a;
    logic [7:0] v;
    logic hit;
    op = w[15:13];
    a = w[12:8];
    v = 8'h00;
    hit = 1'b0;
    if (op == `QP_OP_RD_ACR) begin
      hit = 1'b1;
      a = `QP_ADDR_ACR;
      v = acr_val;
    end else if (op == `QP_OP_RD_REG) begin
      if (a == `QP_ADDR_ACR) begin
        hit = 1'b1;
        v = acr_val;
      end else if (a <= `QP_ADDR_WIPER_3) begin
        hit = 1'b1;
        v = wp[a[1:0]];
      end
    end
    return {hit, `QP_RD_MARK, a, v};
  endfunction

  assign shifted = {st_r.sh[14:0], st_r.sdi_s};
  assign rd_new = read_resp(shifted);
  assign rd_end = read_resp(st_r.sh);

  always_comb begin
    st_nxt = st_r;
    wr_en = 1'b0;
    wr_idx = 2'h0;
    wr_data = 8'h00;
    mid_rst = 1'b0;
    // two flops on every pin before any logic
    st_nxt.sck_m = sck;
    st_nxt.sck_s = st_r.sck_m;
    st_nxt.sck_d = st_r.sck_s;
    st_nxt.cs_m = cs_n;
    st_nxt.cs_s = st_r.cs_m;
    st_nxt.cs_d = st_r.cs_s;
    st_nxt.sdi_m = sdi;
    st_nxt.sdi_s = st_r.sdi_m;
    st_nxt.dip_m = supply_low;
    st_nxt.dip_s = st_r.dip_m;

    unique case (st_r.state)
      QP_ST_WAIT, QP_ST_IDLE: begin
        if (cs_fall) begin
          st_nxt.state = QP_ST_FRAME;
          st_nxt.bcnt = 4'h0;
          st_nxt.got_word = 1'b0;
          st_nxt.sdo = st_r.sh[15];
        end
      end
      QP_ST_FRAME: begin
        if (cs_rise) begin
          st_nxt.state = QP_ST_IDLE;
          // write only on a whole word ending on a byte boundary
          if (st_r.got_word && st_r.bcnt[2:0] == 3'h0) begin
            if (st_r.sh[15:13] == `QP_OP_WR_ACR ||
                (st_r.sh[15:13] == `QP_OP_WR_REG &&
                 st_r.sh[12:8] == `QP_ADDR_ACR)) begin
              st_nxt.acr_shutdown_n_bit_n = st_r.sh[`QP_ACR_SHUTDOWN_N_BIT_BIT];
              st_nxt.acr_od = st_r.sh[`QP_ACR_OD_BIT];
            end else if (st_r.sh[15:13] == `QP_OP_WR_REG &&
                         st_r.sh[12:8] <= `QP_ADDR_WIPER_3) begin
              wr_en = 1'b1;
              wr_idx = st_r.sh[9:8];
              wr_data = st_r.sh[7:0];
            end else if (rd_end[16]) begin
              // chained read: reply waits for the next frame
              st_nxt.sh = rd_end[15:0];
            end
            // anything else is dropped untouched
          end
        end else if (sck_rise) begin
          st_nxt.bcnt = st_r.bcnt + 4'h1;
          if (st_r.bcnt == `QP_WORD_LAST) begin
            st_nxt.got_word = 1'b1;
            if (rd_new[16]) begin
              st_nxt.sh = rd_new[15:0];
            end else begin
              st_nxt.sh = shifted;
            end
          end else begin
            st_nxt.sh = shifted;
          end
        end else if (sck_fall) begin
          st_nxt.sdo = st_r.sh[15];
        end
      end
    endcase

    // supply dip filter, armed only in shutdown
    if (st_r.dip_s && !st_r.acr_shutdown_n_bit_n) begin
      if (st_r.dip_cnt != 4'(`QP_DIP_CYC)) begin
        st_nxt.dip_cnt = st_r.dip_cnt + 4'h1;
      end
      if (st_r.dip_cnt == 4'(`QP_DIP_CYC - 1)) begin
        mid_rst = 1'b1;
      end
    end else begin
      st_nxt.dip_cnt = 4'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= '0;
      st_r.state <= QP_ST_WAIT;
      // select syncs clear: a select held low over reset shows no fall
      st_r.acr_shutdown_n_bit_n <= 1'(`QP_ACR_RST >> `QP_ACR_SHUTDOWN_N_BIT_BIT);
      st_r.acr_od <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  qp_wiper_bank u_bank (
    .clk_sys(clk_sys),
    .rst(rst),
    .mid_rst(mid_rst),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .pos_0(wiper_pos_0),
    .pos_1(wiper_pos_1),
    .pos_2(wiper_pos_2),
    .pos_3(wiper_pos_3)
  );

  // open drain never drives high; push-pull drives both levels
  assign sdo_o = st_r.acr_od ? 1'b0 : st_r.sdo;
  assign sdo_oe = in_frame && (!st_r.acr_od || !st_r.sdo);
  // shutdown only switches the array; wiper values stay put
  assign shutdown_n = st_r.acr_shutdown_n_bit_n;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_idle_released: assert property (
    !in_frame |-> !sdo_oe)
    else $error("sdo driven while deselected");

  a_wait_first_fall: assert property (
    st_r.state == QP_ST_WAIT && !cs_fall |=> st_r.state == QP_ST_WAIT)
    else $error("frame began without a select fall");

  a_no_early_write: assert property (
    st_r.state == QP_ST_WAIT |-> !wr_en)
    else $error("write before first select fall");

  a_write_on_rise: assert property (
    wr_en |-> cs_rise && st_r.got_word)
    else $error("wiper write outside select rise");

  a_sdo_on_fall: assert property (
    in_frame && !cs_rise && sck_fall
    |=> st_r.sdo == $past(st_r.sh[15]))
    else $error("sdo not updated on clock fall");

  a_sdo_stable: assert property (
    in_frame && !sck_fall |=> $stable(st_r.sdo))
    else $error("sdo moved without a clock fall");

  a_shift_msb: assert property (
    in_frame && sck_rise && !cs_rise && st_r.bcnt != `QP_WORD_LAST
    |=> st_r.sh == {$past(st_r.sh[14:0]), $past(st_r.sdi_s)})
    else $error("shift register not msb first");

  a_read_marker: assert property (
    in_frame && sck_rise && !cs_rise && st_r.bcnt == `QP_WORD_LAST
    && rd_new[16] |=> st_r.sh[15:13] == `QP_RD_MARK
    && st_r.sh[12:8] == $past(rd_new[12:8]))
    else $error("read reply marker missing");

  a_open_drain: assert property (
    st_r.acr_od && sdo_oe |-> !sdo_o && !st_r.sdo)
    else $error("open drain drove a one");

  a_dip_filter: assert property (
    mid_rst |-> !st_r.acr_shutdown_n_bit_n && st_r.dip_s
    && st_r.dip_cnt == 4'(`QP_DIP_CYC - 1))
    else $error("mid-scale reset without a long dip");

  a_dip_length: assert property (
    !st_r.dip_s ##1 (st_r.dip_s && !st_r.acr_shutdown_n_bit_n)[*7]
    |-> !mid_rst)
    else $error("dip shorter than filter reset wipers");

  a_bad_addr_safe: assert property (
    cs_rise && in_frame && st_r.sh[15:13] == `QP_OP_WR_REG
    && st_r.sh[12:8] > `QP_ADDR_WIPER_3 && st_r.sh[12:8] != `QP_ADDR_ACR
    |=> $stable(st_r.acr_shutdown_n_bit_n) && $stable(st_r.acr_od))
    else $error("unmapped write changed control");

  c_wiper_write: cover property (wr_en);
  c_read_reply: cover property (
    in_frame && sck_rise && st_r.bcnt == `QP_WORD_LAST && rd_new[16]);
  c_shutdown: cover property ($fell(st_r.acr_shutdown_n_bit_n));
  c_dip_reset: cover property (mid_rst);

endmodule // qp_spi_slave

// ===== rtl/qp_defs.svh
`ifndef QP_DEFS_SVH
`define QP_DEFS_SVH

// clock and glitch timing
`define QP_CLK_NS 25
`define QP_DIP_NS 200
`define QP_DIP_CYC ((`QP_DIP_NS + `QP_CLK_NS - 1) / `QP_CLK_NS)

// register map
`define QP_NUM_WIPERS 4
`define QP_ADDR_WIPER_0 5'h00
`define QP_ADDR_WIPER_1 5'h01
`define QP_ADDR_WIPER_2 5'h02
`define QP_ADDR_WIPER_3 5'h03
`define QP_ADDR_ACR 5'h10
`define QP_WIPER_RST 8'h40
`define QP_ACR_RST 8'h40
`define QP_ACR_SHUTDOWN_N_BIT_BIT 6
`define QP_ACR_OD_BIT 1

// instruction byte
`define QP_OP_NOP 3'h0
`define QP_OP_RD_ACR 3'h1
`define QP_OP_WR_ACR 3'h3
`define QP_OP_RD_REG 3'h4
`define QP_OP_WR_REG 3'h6
`define QP_RD_MARK 3'h7
`define QP_WORD_LAST 4'hf

`endif

// ===== rtl/qp_pkg.sv
package qp_pkg;

  typedef enum logic [1:0] {
    QP_ST_WAIT,
    QP_ST_IDLE,
    QP_ST_FRAME
  } qp_state_e;

  typedef logic [7:0] qp_byte_t;

  typedef struct packed {
    qp_state_e state;
    logic sck_m;
    logic sck_s;
    logic sck_d;
    logic cs_m;
    logic cs_s;
    logic cs_d;
    logic sdi_m;
    logic sdi_s;
    logic dip_m;
    logic dip_s;
    logic [3:0] bcnt;
    logic got_word;
    logic [15:0] sh;
    logic sdo;
    logic acr_od;
    logic acr_shutdown_n_bit_n;
    logic [3:0] dip_cnt;
  } qp_core_s;

  typedef struct packed {
    logic [3:0][7:0] pos;
  } qp_bank_s;

endpackage

// ===== rtl/qp_wiper_bank.sv
`timescale 1ns/10ps
`include "qp_defs.svh"

module qp_wiper_bank import qp_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic mid_rst,
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire logic [7:0] wr_data,
  output logic [7:0] pos_0,
  output logic [7:0] pos_1,
  output logic [7:0] pos_2,
  output logic [7:0] pos_3
);

  qp_bank_s st_r;
  qp_bank_s st_nxt;
  logic [3:0][7:0] pos_all;

  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < `QP_NUM_WIPERS; i++) begin
      if (mid_rst) begin
        st_nxt.pos[i] = `QP_WIPER_RST;
      end else if (wr_en && wr_idx == 2'(i)) begin
        st_nxt.pos[i] = wr_data;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= {`QP_NUM_WIPERS{`QP_WIPER_RST}};
    end else begin
      st_r <= st_nxt;
    end
  end

  // one register per potentiometer, read straight from the flops
  genvar g;
  generate
    for (g = 0; g < `QP_NUM_WIPERS; g++) begin : g_pos
      assign pos_all[g] = st_r.pos[g];
    end
  endgenerate

  assign pos_0 = pos_all[0];
  assign pos_1 = pos_all[1];
  assign pos_2 = pos_all[2];
  assign pos_3 = pos_all[3];

  a_midscale_load: assert property (@(posedge clk_sys) disable iff (rst)
    mid_rst |=> st_r.pos == {4{`QP_WIPER_RST}})
    else $error("wipers not at mid-scale after dip");

endmodule // qp_wiper_bank

// ===== tb/qp_host_model.sv
`timescale 1ns/10ps

module qp_host_model (
  input wire logic clk_sys,
  input wire logic sdo_line,
  output logic sck,
  output logic cs_n,
  output logic sdi
);
  // select starts low: the first frame shows no falling edge
  initial begin
    sck = 1'b0;
    cs_n = 1'b0;
    sdi = 1'b0;
  end

  task automatic xfer(input logic [31:0] tx, input int nb,
                      output logic [31:0] rx);
    rx = '0;
    @(posedge clk_sys);
    cs_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    for (int i = nb * 8 - 1; i >= 0; i--) begin
      sdi <= tx[i];
      repeat (4) @(posedge clk_sys);
      sck <= 1'b1;
      rx = {rx[30:0], sdo_line};
      repeat (4) @(posedge clk_sys);
      sck <= 1'b0;
    end
    repeat (8) @(posedge clk_sys);
    cs_n <= 1'b1;
    sdi <= ~tx[0];
    repeat (16) @(posedge clk_sys);
  endtask
endmodule // qp_host_model

// ===== tb/tb_top.sv
`timescale 1ns/10ps
`include "qp_defs.svh"

module tb_top;
  logic clk_sys, rst, supply_low, sck, cs_n, sdi, sdo_line;
  logic sdo_o, sdo_oe, shutdown_n, od_mode, od_bad;
  logic [7:0] wp [4];
  logic [7:0] exp_w [4];
  logic [31:0] rx;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;

  // board pull-up keeps a released line high
  assign sdo_line = (sdo_oe === 1'b1) ? sdo_o : 1'b1;

  qp_spi_slave dut (.clk_sys(clk_sys), .rst(rst), .sck(sck),
    .cs_n(cs_n), .sdi(sdi), .supply_low(supply_low), .sdo_o(sdo_o),
    .sdo_oe(sdo_oe), .shutdown_n(shutdown_n), .wiper_pos_0(wp[0]),
    .wiper_pos_1(wp[1]), .wiper_pos_2(wp[2]), .wiper_pos_3(wp[3]));

  qp_host_model host (.clk_sys(clk_sys), .sdo_line(sdo_line),
    .sck(sck), .cs_n(cs_n), .sdi(sdi));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // open-drain may only pull low
  always @(posedge clk_sys) begin
    cycles++;
    if (od_mode && sdo_oe === 1'b1 && sdo_o !== 1'b0) od_bad <= 1'b1;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic check(input logic [7:0] got, exp, input string m);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ins, input logic [7:0] d);
    host.xfer({16'h0000, ins, d}, 2, rx);
  endtask

  task automatic rd(input logic [7:0] ins, mark, exp);
    host.xfer({ins, 24'h00_0000}, 4, rx);
    check(rx[15:8], mark, "read marker");
    check(rx[7:0], exp, "read data");
    check(sdo_oe, 1'b0, "sdo released");
  endtask

  task automatic chk_w(input string m);
    for (int i = 0; i < 4; i++) check(wp[i], exp_w[i], m);
  endtask

  task automatic t_reset;
    for (int i = 0; i < 4; i++) exp_w[i] = `QP_WIPER_RST;
    chk_w("power-up wiper");
    check(shutdown_n, 1'b1, "shutdown default");
    check(sdo_oe, 1'b0, "idle sdo");
    wr(8'hc0, 8'h11);
    chk_w("frame before select fall");
  endtask

  task automatic t_wr_rd;
    logic [7:0] v [4];
    v = '{8'h00, 8'h7f, 8'h55, 8'h2a};
    for (int i = 0; i < 4; i++) begin
      wr({6'b110000, i[1:0]}, v[i]);
      exp_w[i] = v[i];
    end
    chk_w("wiper write");
    for (int i = 0; i < 4; i++)
      rd({6'b100000, i[1:0]}, {6'b111000, i[1:0]}, v[i]);
    rd(8'h23, 8'hf0, 8'h40);
    rd(8'h90, 8'hf0, 8'h40);
  endtask

  task automatic t_ignored;
    logic [7:0] ins [5];
    ins = '{8'h00, 8'h41, 8'hab, 8'he2, 8'hc5};
    foreach (ins[k]) wr(ins[k], 8'h33);
    chk_w("ignored word");
    check(shutdown_n, 1'b1, "control kept");
  endtask

  task automatic dip(input int n);
    @(posedge clk_sys);
    supply_low <= 1'b1;
    repeat (n) @(posedge clk_sys);
    supply_low <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic t_shutdown;
    wr(8'h60, 8'h00);
    check(shutdown_n, 1'b0, "enter shutdown");
    chk_w("held in shutdown");
    wr(8'hd0, 8'h40);
    check(shutdown_n, 1'b1, "leave shutdown");
    chk_w("restored wiper");
    dip(16);
    chk_w("dip while active");
    wr(8'h7f, 8'h00);
    dip(4);
    chk_w("short dip");
    dip(12);
    for (int i = 0; i < 4; i++) exp_w[i] = `QP_WIPER_RST;
    chk_w("long dip");
    wr(8'h60, 8'h40);
  endtask

  // the od_bad monitor proves the line is pulled only downward
  task automatic t_open_drain;
    wr(8'hc1, 8'h5a);
    exp_w[1] = 8'h5a;
    wr(8'h60, 8'h42);
    od_mode = 1'b1;
    rd(8'h81, 8'he1, 8'h5a);
    rd(8'h20, 8'hf0, 8'h42);
    check(od_bad, 1'b0, "open-drain high drive");
    od_mode = 1'b0;
    wr(8'h60, 8'h40);
    rd(8'h81, 8'he1, 8'h5a);
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    supply_low = 1'b0;
    od_mode = 1'b0;
    od_bad = 1'b0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_wr_rd();
    t_ignored();
    t_shutdown();
    t_open_drain();
    close_out();
  end
endmodule // tb_top
